/* src/tdm_connection_memory_access.sv */
`timescale 1ns/100ps
`include "tdm_access_defines.svh"
// Notes on behaviour
// - With A13 high a host access goes to data or connection memory.
// - With A13 low a host access goes to the internal registers.
// - Control register bits 1-0 pick data memory, low or high connection word.
// - A 2.048 Mbps stream uses channels 0 to 31 only.
// - A 4.096 Mbps stream uses channels 0 to 63 only.
// - A 8.192 Mbps stream uses channels 0 to 127 only.
// - A 16.384 Mbps stream uses channels 0 to 255.
// - Low connection word bit 0 clear means normal channel switching.
// - Each input stream has a read-only 16-bit BER error count, writes ignored.
// - In special mode bits 2-1 pick tristate, message or BER test, 11 reserved.
module tdm_connection_memory_access
    import tdm_access_pkg::*;
#(
    parameter int STREAMS = 32,
    parameter int CHANS   = 256
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   resetn,
    // Host bus
    input  wire logic [`ADDR_W-1:0]     addr,
    input  wire logic [`DATA_W-1:0]     wdata,
    input  wire logic                   wr,
    input  wire logic                   rd,
    output logic      [`DATA_W-1:0]     rdata,
    output logic                        rvalid,
    // Stream rates and BER events
    input  wire logic [2*STREAMS-1:0]   stream_rate,
    input  wire logic [STREAMS-1:0]     ber_error_pulse,
    // Decoded connection word of the looked-up channel
    input  wire logic [`ADDR_W-1:0]     lookup_addr,
    output conn_decode_t                lookup_conn,
    output logic [1:0]                  mem_select
);
    localparam int DEPTH = STREAMS * CHANS;

    logic [`DATA_W-1:0] data_mem [DEPTH];
    logic [`DATA_W-1:0] conn_low [DEPTH];
    logic [`DATA_W-1:0] conn_high[DEPTH];

    logic [`DATA_W-1:0] ctrl_reg, ctrl_next;
    logic [`DATA_W-1:0] rdata_reg, rdata_next;
    logic               rvalid_reg, rvalid_next;
    logic [`DATA_W-1:0] ber_error_count_reg [STREAMS];
    logic [`DATA_W-1:0] ber_error_count_next[STREAMS];
    conn_decode_t       lookup_reg, lookup_next;

    function automatic logic [7:0] chan_max(input logic [1:0] rate);
        case (rate)
            `RATE_2M:  chan_max = `CHAN_MAX_2M;
            `RATE_4M:  chan_max = `CHAN_MAX_4M;
            `RATE_8M:  chan_max = `CHAN_MAX_8M;
            default:   chan_max = `CHAN_MAX_16M;
        endcase
    endfunction

    function automatic mem_addr_t split_addr(input logic [`ADDR_W-1:0] a);
        split_addr.stream  = a[`STREAM_HI:`STREAM_LO];
        split_addr.channel = a[`CHAN_HI:`CHAN_LO];
    endfunction

    function automatic logic chan_ok(input mem_addr_t m, input logic [2*STREAMS-1:0] r);
        chan_ok = m.channel <= chan_max(r[2*m.stream +: 2]);
    endfunction

    mem_addr_t host_m;
    mem_addr_t look_m;
    logic      mem_space;
    logic      mem_ok;
    logic [`DATA_W-1:0] cw;

    assign host_m    = split_addr(addr);
    assign look_m    = split_addr(lookup_addr);
    assign mem_space = addr[`MEM_SPACE_BIT];
    assign mem_ok    = chan_ok(host_m, stream_rate);
    assign cw        = conn_low[{look_m.stream, look_m.channel}];

    // Register and read path
    always_comb begin
        ctrl_next   = ctrl_reg;
        rdata_next  = rdata_reg;
        rvalid_next = rd;
        if (rd) begin
            rdata_next = '0;
            if (mem_space) begin
                if (mem_ok) begin
                    case (ctrl_reg[1:0])
                        `SEL_DATA_MEM:  rdata_next = data_mem[{host_m.stream, host_m.channel}];
                        `SEL_CONN_LOW:  rdata_next = conn_low[{host_m.stream, host_m.channel}];
                        `SEL_CONN_HIGH: rdata_next = conn_high[{host_m.stream, host_m.channel}];
                        default:        rdata_next = '0;
                    endcase
                end
            end else if (addr == `CTRL_REG_ADDR) begin
                rdata_next = ctrl_reg;
            end else if (addr >= `BER_COUNT_BASE && addr <= `BER_COUNT_LAST) begin
                rdata_next = ber_error_count_reg[addr[4:0]];
            end
        end
        if (wr && !mem_space && addr == `CTRL_REG_ADDR) begin
            ctrl_next = wdata;
        end
    end

    // Per-stream BER error counters, host writes have no path here
    genvar g;
    generate
        for (g = 0; g < STREAMS; g++) begin : g_ber
            always_comb begin
                ber_error_count_next[g] = ber_error_count_reg[g];
                if (ber_error_pulse[g] && ber_error_count_reg[g] != 16'hffff) begin
                    ber_error_count_next[g] = ber_error_count_reg[g] + 16'h0001;
                end
            end
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    ber_error_count_reg[g] <= `BER_COUNT_RESET;
                end else begin
                    ber_error_count_reg[g] <= ber_error_count_next[g];
                end
            end
        end
    endgenerate

    // Connection word decode
    always_comb begin
        lookup_next                            = '0;
        lookup_next.switching                  = ~cw[`CWL_MODE_BIT];
        lookup_next.law_conversion_enable      = cw[`CWL_LAW_BIT];
        if (!cw[`CWL_MODE_BIT]) begin
            lookup_next.delay_variable         = cw[`CWL_DELAY_BIT];
            lookup_next.source_stream_field    = cw[`CWL_SSTREAM_HI:`CWL_SSTREAM_LO];
            lookup_next.source_channel_field   = cw[`CWL_SCHAN_HI:`CWL_SCHAN_LO];
        end else begin
            lookup_next.special_channel_mode_field = cw[`CWL_SPEC_HI:`CWL_SPEC_LO];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl_reg   <= `CTRL_RESET;
            rdata_reg  <= '0;
            rvalid_reg <= 1'b0;
            lookup_reg <= '0;
        end else begin
            ctrl_reg   <= ctrl_next;
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
            lookup_reg <= lookup_next;
        end
    end

    // Memory writes
    always_ff @(posedge clk) begin
        if (wr && mem_space && mem_ok) begin
            case (ctrl_reg[1:0])
                `SEL_DATA_MEM:  data_mem[{host_m.stream, host_m.channel}]  <= wdata;
                `SEL_CONN_LOW:  conn_low[{host_m.stream, host_m.channel}]  <= wdata;
                `SEL_CONN_HIGH: conn_high[{host_m.stream, host_m.channel}] <= wdata;
                default: ;
            endcase
        end
    end

    assign rdata       = rdata_reg;
    assign rvalid      = rvalid_reg;
    assign lookup_conn = lookup_reg;
    assign mem_select  = ctrl_reg[1:0];

    property p_ctrl_write;
        @(posedge clk) disable iff (!resetn)
        (wr && !addr[13] && addr == 14'h0000) |=> (mem_select == $past(wdata[1:0]));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("Control write lost");

    property p_ctrl_mem_untouched;
        @(posedge clk) disable iff (!resetn)
        (wr && addr[13]) |=> $stable(mem_select);
    endproperty
    a_ctrl_mem_untouched: assert property (p_ctrl_mem_untouched) else $error("Memory write hit reg");

    property p_ber_ro;
        @(posedge clk) disable iff (!resetn)
        (wr && !ber_error_pulse[0]) |=> $stable(ber_error_count_reg[0]);
    endproperty
    a_ber_ro: assert property (p_ber_ro) else $error("BER count changed by write");

    property p_ber_inc;
        @(posedge clk) disable iff (!resetn)
        (ber_error_pulse[0] && ber_error_count_reg[0] != 16'hffff)
            |=> ber_error_count_reg[0] == $past(ber_error_count_reg[0]) + 16'h0001;
    endproperty
    a_ber_inc: assert property (p_ber_inc) else $error("BER count missed");

    property p_rvalid;
        @(posedge clk) disable iff (!resetn)
        rd |=> rvalid;
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("Read not answered");

    property p_switch;
        @(posedge clk) disable iff (!resetn)
        (!cw[0]) |=> (lookup_conn.switching && lookup_conn.special_channel_mode_field == 2'h0);
    endproperty
    a_switch: assert property (p_switch) else $error("Switching decode wrong");

    property p_special;
        @(posedge clk) disable iff (!resetn)
        cw[0] |=> (!lookup_conn.switching && lookup_conn.source_stream_field == 5'h00);
    endproperty
    a_special: assert property (p_special) else $error("Special decode wrong");

    property p_range_2m;
        @(posedge clk) disable iff (!resetn)
        (rd && addr[13] && stream_rate[2*host_m.stream +: 2] == 2'h0 && addr[7:5] != 3'h0)
            |=> rdata == 16'h0000;
    endproperty
    a_range_2m: assert property (p_range_2m) else $error("Out of range channel read");

endmodule // tdm_connection_memory_access

/* pkg/tdm_access_defines.svh */
`ifndef TDM_ACCESS_DEFINES_SVH
`define TDM_ACCESS_DEFINES_SVH

`define ADDR_W             14
`define DATA_W             16
`define MEM_SPACE_BIT      13
`define STREAM_HI          12
`define STREAM_LO          8
`define CHAN_HI            7
`define CHAN_LO            0
`define CTRL_REG_ADDR      14'h0000
`define BER_COUNT_BASE     14'h0360
`define BER_COUNT_LAST     14'h037f
`define BER_COUNT_RESET    16'h0000
`define CTRL_RESET         16'h0000
`define SEL_DATA_MEM       2'h0
`define SEL_CONN_LOW       2'h1
`define SEL_CONN_HIGH      2'h2
`define RATE_2M            2'h0
`define RATE_4M            2'h1
`define RATE_8M            2'h2
`define RATE_16M           2'h3
`define CHAN_MAX_2M        8'h1f
`define CHAN_MAX_4M        8'h3f
`define CHAN_MAX_8M        8'h7f
`define CHAN_MAX_16M       8'hff
`define CWL_LAW_BIT        15
`define CWL_DELAY_BIT      14
`define CWL_SSTREAM_HI     13
`define CWL_SSTREAM_LO     9
`define CWL_SCHAN_HI       8
`define CWL_SCHAN_LO       1
`define CWL_MODE_BIT       0
`define CWL_SPEC_HI        2
`define CWL_SPEC_LO        1

`endif

/* pkg/tdm_access_pkg.sv */
package tdm_access_pkg;
    typedef enum logic [1:0] {
        spec_tristate = 2'h0,
        spec_message  = 2'h1,
        spec_ber_test = 2'h2,
        spec_reserved = 2'h3
    } special_mode_t;

    typedef struct packed {
        logic        switching;
        logic        law_conversion_enable;
        logic        delay_variable;
        logic [4:0]  source_stream_field;
        logic [7:0]  source_channel_field;
        logic [1:0]  special_channel_mode_field;
    } conn_decode_t;

    typedef struct packed {
        logic [4:0] stream;
        logic [7:0] channel;
    } mem_addr_t;
endpackage

/* tb/tdm_host_model.sv */
`timescale 1ns/100ps
`include "tdm_access_defines.svh"
module tdm_host_model (
    // Clock
    input  wire logic               clk,
    // Host bus
    output logic [`ADDR_W-1:0]      addr,
    output logic [`DATA_W-1:0]      wdata,
    output logic                    wr,
    output logic                    rd,
    input  wire logic [`DATA_W-1:0] rdata,
    input  wire logic               rvalid
);
    initial begin
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
    end
    // Memory space address
    function automatic logic [13:0] mem_at(logic [4:0] s, logic [7:0] c);
        return {1'b1, s, c};
    endfunction
    // Register space address
    function automatic logic [13:0] reg_at(logic [12:0] o);
        return {1'b0, o};
    endfunction
    task automatic bus_wr(input logic [13:0] a, input logic [15:0] d);
        @(posedge clk);
        #1;
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clk);
        #1;
        wr = 1'b0;
        wdata = ~d;
    endtask
    task automatic bus_rd(input logic [13:0] a, output logic [15:0] d, output logic v);
        @(posedge clk);
        #1;
        addr = a;
        rd = 1'b1;
        @(posedge clk);
        #1;
        rd = 1'b0;
        d = rdata;
        v = rvalid;
    endtask
endmodule // tdm_host_model

/* tb/tdm_connection_memory_access_tb.sv */
`timescale 1ns/100ps
`include "tdm_access_defines.svh"
module tdm_connection_memory_access_tb;
    import tdm_access_pkg::*;
    logic clk, resetn, wr, rd, rvalid, v;
    logic [13:0] addr, lookup_addr;
    logic [15:0] wdata, rdata, rv, d;
    logic [63:0] stream_rate;
    logic [31:0] ber_error_pulse;
    logic [1:0] mem_select;
    logic [4:0] s;
    logic [7:0] mx;
    conn_decode_t lookup_conn;
    int error_cnt, total_checks, r, k;
    always #25 clk = ~clk;
    tdm_connection_memory_access dut_u (.clk(clk), .resetn(resetn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rvalid(rvalid),
        .stream_rate(stream_rate), .ber_error_pulse(ber_error_pulse),
        .lookup_addr(lookup_addr), .lookup_conn(lookup_conn), .mem_select(mem_select));
    tdm_host_model host_u (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .rvalid(rvalid));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic rd_chk(input logic [13:0] a, input logic [15:0] exp);
        host_u.bus_rd(a, rv, v);
        check({15'h0, v}, 16'h1);
        check(rv, exp);
    endtask
    function automatic logic [7:0] chan_max(int rate);
        case (rate)
            0: return `CHAN_MAX_2M;
            1: return `CHAN_MAX_4M;
            2: return `CHAN_MAX_8M;
            default: return `CHAN_MAX_16M;
        endcase
    endfunction
    task automatic look(input logic [13:0] a);
        lookup_addr = a;
        repeat (2) @(posedge clk);
        #1;
    endtask
    initial begin
        #1_000_000;
        error_cnt++;
        $display("[ERR] %0t ns: timeout", $time);
        finish_test;
    end
    initial begin
        clk = 0;
        resetn = 0;
        stream_rate = '0;
        ber_error_pulse = '0;
        lookup_addr = '0;
        void'($urandom(82994));
        repeat (20) @(posedge clk);
        #1;
        resetn = 1;
        check(rdata, 16'h0);
        check({14'h0, mem_select}, 16'h0);
        rd_chk(host_u.reg_at(13'h0360), 16'h0);
        rd_chk(host_u.reg_at(13'h0100), 16'h0);
        $display("reset test done");
        for (r = 2; r >= 0; r--) begin
            host_u.bus_wr(host_u.reg_at(13'h0), 16'(3 - r) & 16'h3);
            check({14'h0, mem_select}, 16'(3 - r) & 16'h3);
        end
        for (r = 0; r < 3; r++) begin
            host_u.bus_wr(host_u.reg_at(13'h0), 16'(r));
            host_u.bus_wr(host_u.mem_at(5'h1, 8'h2), 16'h0a50 + 16'(r));
        end
        for (r = 0; r < 3; r++) begin
            host_u.bus_wr(host_u.reg_at(13'h0), 16'(r));
            rd_chk(host_u.mem_at(5'h1, 8'h2), 16'h0a50 + 16'(r));
        end
        host_u.bus_wr(host_u.reg_at(13'h0), 16'h3);
        rd_chk(host_u.mem_at(5'h1, 8'h2), 16'h0);
        host_u.bus_wr(host_u.reg_at(13'h0), `SEL_CONN_LOW);
        check({14'h0, mem_select}, 16'h1);
        $display("select test done");
        for (r = 0; r < 4; r++) begin
            s = 5'($urandom_range(31));
            stream_rate = {$urandom, $urandom};
            stream_rate[2*s +: 2] = 2'(r);
            mx = chan_max(r);
            d = 16'($urandom);
            d[0] = 1'b0;
            host_u.bus_wr(host_u.mem_at(s, mx), d);
            rd_chk(host_u.mem_at(s, mx), d);
            check({14'h0, mem_select}, 16'h1);
            if (r < 3) begin
                host_u.bus_wr(host_u.mem_at(s, mx + 8'h1), 16'hffff);
                rd_chk(host_u.mem_at(s, mx + 8'h1), 16'h0);
            end
            look(host_u.mem_at(s, mx));
            check({15'h0, lookup_conn.switching}, 16'h1);
            check({1'b0, lookup_conn.law_conversion_enable, lookup_conn.delay_variable,
                lookup_conn.source_stream_field, lookup_conn.source_channel_field},
                {1'b0, d[15:1]});
        end
        $display("connection test done");
        for (r = 0; r < 4; r++) begin
            d = 16'($urandom);
            d[2:0] = {2'(r), 1'b1};
            host_u.bus_wr(host_u.mem_at(s, 8'h0), d);
            look(host_u.mem_at(s, 8'h0));
            check({15'h0, lookup_conn.switching}, 16'h0);
            check({14'h0, lookup_conn.special_channel_mode_field}, 16'(r));
        end
        $display("special test done");
        s = 5'($urandom_range(31));
        k = $urandom_range(20, 5);
        repeat (k) begin
            @(posedge clk);
            #1;
            ber_error_pulse[s] = 1'b1;
            @(posedge clk);
            #1;
            ber_error_pulse[s] = 1'b0;
        end
        rd_chk(host_u.reg_at(13'h0360 + 13'(s)), 16'(k));
        host_u.bus_wr(host_u.reg_at(13'h0360 + 13'(s)), 16'h1234);
        rd_chk(host_u.reg_at(13'h0360 + 13'(s)), 16'(k));
        $display("error count test done");
        finish_test;
    end
endmodule // tdm_connection_memory_access_tb
